// *** src/fwtd_consts.svh ***
/*
  Constants of the firmware trap dispatch block: register offsets,
  field positions, reset values, opcodes, vector layout and cycle counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef FWTD_CONSTS_SVH
`define FWTD_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses) and reset values
// ----------------------------------------------------------------
`define FWTD_OFS_BASE_LO   8'h00
`define FWTD_OFS_BASE_HI   8'h04
`define FWTD_OFS_CTRL      8'h08
`define FWTD_OFS_STATUS    8'h0c
`define FWTD_OFS_EXC_LO    8'h10
`define FWTD_OFS_EXC_HI    8'h14
`define FWTD_RST_BASE      64'h0000_0000_0000_0000
`define FWTD_RST_CTRL      8'h00
`define FWTD_RST_EXC       64'h0000_0000_0000_0001
`define FWTD_BASE_LSB      14
// Control fields
`define FWTD_CTRL_KRAW     0
`define FWTD_CTRL_FPE      1
`define FWTD_CTRL_CM       3:2
`define FWTD_CTRL_DCM      5:4
`define FWTD_CTRL_ALTM     7:6
`define FWTD_MODE_KERNEL   2'h0
// ----------------------------------------------------------------
// Opcodes and instruction fields
// ----------------------------------------------------------------
`define FWTD_OP_CALL       6'h00
`define FWTD_OP_RLD        6'h1b
`define FWTD_OP_RST        6'h1f
`define FWTD_OP_RET        6'h1e
`define FWTD_OP_IRD        6'h19
`define FWTD_OP_IWR        6'h1d
`define FWTD_FN_PRIV_MAX   8'h3f
`define FWTD_FN_ILL_LO     8'h40
`define FWTD_FN_ILL_HI     8'h7f
`define FWTD_FN_MAX        8'hbf
`define FWTD_RET_PREFETCH  2'h2
`define FWTD_IPR_SLOW_BIT  8
// ----------------------------------------------------------------
// Trap vectors: index times step gives offsets 0000 to 0580
// ----------------------------------------------------------------
`define FWTD_NTRAP         12
`define FWTD_T_INTR        2
`define FWTD_T_ITBM        3
`define FWTD_T_DTBM        4
`define FWTD_T_ILLEGAL_OPCODE_TRAP      9
`define FWTD_T_FEN         11
// ----------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------
`define FWTD_FLOW_MIN      2'h2
`endif

// *** src/fwtd_pkg.sv ***
/*
  Types of the firmware trap dispatch block.
  Assumes fwtd_consts.svh is on the include path.
*/
package fwtd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BARRIER, ST_ISSUE, ST_FLOW} fwtd_state_t;
  // Raw memory access handed to the data stream
  typedef struct packed {
    logic        valid;
    logic        store;
    logic        physical_address_select;
    logic        chk_write;
    logic        quad;
    logic        lock_cond;
    logic        pte_fetch;
    logic [1:0]  mode;
    logic [4:0]  ra;
    logic [63:0] addr;
  } fwtd_raw_t;
  // Internal register transfer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  latency;
    logic [4:0]  ra;
    logic [15:0] index;
  } fwtd_ipr_t;
  // Fetch redirect
  typedef struct packed {
    logic        valid;
    logic        prefetch;
    logic [63:0] pc;
  } fwtd_redir_t;
endpackage

// *** src/fwtd_dispatch.sv ***
/*
  Firmware entry and privileged opcode decode inside the fetch/decode unit,
  with an AXI4-Lite register slave for base, control and return address.
  Assumes the pipeline holds instr_valid until fetch_stall is low, and
  reports pipe_empty when no older instruction can still trap.
*/
// Operation
// - bad call functions start illegal-opcode flow
// - call target built from base and function
// - call issues to pipe one after barrier
// - call saves next PC, pushes return stack
// - call takes four cycles at least
// - trap saves return PC, barrier; no replays
// - stack gets trap PC, later if imprecise
// - first eight trap vectors by priority
// - check, illegal, arithmetic, float vectors follow
// - sign error hides miss; icache miss swaps
// - float disabled or bad type traps
// - decode the five privileged opcodes
// - privileged opcodes illegal outside firmware mode, except in kernel mode with KRAW set
// - physical skips checks; alternate mode selectable
// - write check adds write faults
// - base plus 10-bit displacement, no alignment
// - page table fetch checks in kernel
// - raw store pipe zero, conditional, zero bits
// - return jumps to saved address, pipe one
// - return prefetch or stall variant
// - read latency one or two cycles
// - firmware base held in register
// - firmware mode masks interrupts
`timescale 1ns/1ps
`include "fwtd_consts.svh"
module fwtd_dispatch (
  input  wire logic                 aclk,          // Core clock
  input  wire logic                 aresetn,       // Synchronous reset, low
  input  wire logic [7:0]           s_axi_awaddr,  // Write address
  input  wire logic                 s_axi_awvalid, // Write address valid
  output logic                      s_axi_awready, // Write address ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Byte enables
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output logic                      s_axi_wready,  // Write data ready
  output logic [1:0]                s_axi_bresp,   // Write response
  output logic                      s_axi_bvalid,  // Write response valid
  input  wire logic                 s_axi_bready,  // Response accepted
  input  wire logic [7:0]           s_axi_araddr,  // Read address
  input  wire logic                 s_axi_arvalid, // Read address valid
  output logic                      s_axi_arready, // Read address ready
  output logic [31:0]               s_axi_rdata,   // Read data
  output logic [1:0]                s_axi_rresp,   // Read response
  output logic                      s_axi_rvalid,  // Read data valid
  input  wire logic                 s_axi_rready,  // Read accepted
  input  wire logic                 instr_valid,   // Decode slot holds an instruction
  input  wire logic [31:0]          instr_word,    // Instruction bits
  input  wire logic [63:0]          instr_pc,      // Its PC
  input  wire logic [63:0]          instr_rb_val,  // Base register value
  input  wire logic                 instr_fp,      // Float load, store or operate
  input  wire logic                 instr_fp_std,  // Standard float operate
  input  wire logic [1:0]           instr_fp_type, // 0 S, 1 T, 2 Q, 3 other
  input  wire logic [11:0]          trap_req,      // Hardware trap requests by index
  input  wire logic                 trap_precise,  // Trap is precise
  input  wire logic [63:0]          trap_pc,       // Trapping instruction PC
  input  wire logic [63:0]          trap_ret_pc,   // Return PC for the trap
  input  wire logic                 dsign_err,     // Data address sign error
  input  wire logic                 icache_miss,   // Instruction cache miss
  input  wire logic                 pipe_empty,    // No older op can trap
  output logic                      fetch_stall,   // Fetch/decode held
  output logic                      firmware_mode, // Firmware mode flag
  output logic                      issue_pipe_one,// Call or return issued to pipe one
  output logic                      raw_pipe_zero, // Raw store or conditional load slotted to pipe zero
  output logic                      ras_push,      // Push return stack
  output logic [63:0]               ras_push_pc,   // Pushed PC
  output logic [63:0]               exc_ret_addr,  // exception_return_address
  output fwtd_pkg::fwtd_redir_t     redirect,      // Fetch redirect
  output fwtd_pkg::fwtd_raw_t       raw_op,        // Raw load or store
  output fwtd_pkg::fwtd_ipr_t       ipr_op         // Internal register access
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fwtd_pkg::fwtd_state_t state, next_state;
  logic [1:0]            cnt, next_cnt;
  logic [63:0]           target, next_target;
  logic                  is_call, next_is_call;
  logic [3:0]            last_vec, next_last_vec;
  logic                  next_fetch_stall, next_fw_mode, next_issue, next_pz;
  logic                  next_ras_push;
  logic [63:0]           next_ras_pc, next_exc, next_exc_all;
  fwtd_pkg::fwtd_redir_t next_redirect;
  fwtd_pkg::fwtd_raw_t   next_raw;
  fwtd_pkg::fwtd_ipr_t   next_ipr;
  logic [63:0]           base, next_base;
  logic [7:0]            ctrl, next_ctrl;
  // Bus side
  logic                  aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0]            aw_q, next_aw_q;
  logic [31:0]           w_q, next_w_q;
  logic [3:0]            s_q, next_s_q;
  logic                  next_bvalid, next_rvalid;
  logic [1:0]            next_bresp, next_rresp;
  logic [31:0]           next_rdata, rd_mux;
  logic                  rd_ok;
  // Decode helpers
  logic [5:0]            opc;
  logic [7:0]            fn;
  logic                  kernel, priv_ok, call_bad, fen_hit, ill_hit;
  logic [11:0]           req;
  logic                  any_req;
  logic [3:0]            vec;

  // Byte-lane merge of a bus write into one word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode and trap selection
  // ----------------------------------------------------------------
  // Internal illegal and float traps join the hardware requests so a
  // single priority encoder chooses the entry point
  always_comb begin
    opc     = instr_word[31:26];
    fn      = instr_word[7:0];
    kernel  = ctrl[`FWTD_CTRL_CM] == `FWTD_MODE_KERNEL;
    priv_ok = firmware_mode || (kernel && ctrl[`FWTD_CTRL_KRAW]);
    call_bad = (fn >= `FWTD_FN_ILL_LO && fn <= `FWTD_FN_ILL_HI) || (fn > `FWTD_FN_MAX)
               || (fn <= `FWTD_FN_PRIV_MAX && !kernel);
    fen_hit = (instr_fp && !ctrl[`FWTD_CTRL_FPE])
              || (instr_fp_std && instr_fp_type == 2'h3);
    ill_hit = 1'b0;
    case (opc)
      `FWTD_OP_CALL: ill_hit = call_bad;
      `FWTD_OP_RLD:  ill_hit = !priv_ok;
      `FWTD_OP_RST:  ill_hit = !priv_ok || instr_word[13] || instr_word[11];
      `FWTD_OP_RET:  ill_hit = !priv_ok || instr_word[13:0] != 14'h0000
                               || !instr_word[15];
      `FWTD_OP_IRD, `FWTD_OP_IWR:
        ill_hit = !priv_ok || instr_word[25:21] != instr_word[20:16];
      default:       ill_hit = 1'b0;
    endcase
    req = trap_req;
    if (instr_valid) begin
      req[`FWTD_T_ILLEGAL_OPCODE_TRAP] = req[`FWTD_T_ILLEGAL_OPCODE_TRAP] | ill_hit;
      req[`FWTD_T_FEN]    = req[`FWTD_T_FEN] | (fen_hit & !ill_hit);
    end
    if (firmware_mode) begin
      req[`FWTD_T_INTR] = 1'b0;
    end
    if (dsign_err) begin
      req[`FWTD_T_DTBM] = 1'b0;
    end
    if (icache_miss && req[`FWTD_T_ITBM]) begin
      req[`FWTD_T_INTR] = 1'b0;
    end
    any_req = |req;
    vec = 4'h0;
    for (int i = `FWTD_NTRAP - 1; i >= 0; i--) begin
      if (req[i]) begin
        vec = 4'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Dispatch sequencer
  // ----------------------------------------------------------------
  // Calls and traps share barrier, issue and flow; fetch stalls throughout
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_target   = target;
    next_is_call  = is_call;
    next_last_vec = last_vec;
    next_fw_mode  = firmware_mode;
    next_issue    = 1'b0;
    next_pz       = 1'b0;
    next_ras_push = 1'b0;
    next_ras_pc   = ras_push_pc;
    next_exc      = exc_ret_addr;
    next_redirect = '0;
    next_raw      = '0;
    next_ipr      = '0;
    case (state)
      fwtd_pkg::ST_IDLE: begin
        if (any_req && !fetch_stall) begin
          next_is_call  = 1'b0;
          next_last_vec = vec;
          next_target   = {base[63:`FWTD_BASE_LSB], 3'h0, vec, 6'h00, 1'b1};
          next_ras_push = 1'b1;
          if (trap_req[vec]) begin
            next_exc    = trap_ret_pc;
            next_ras_pc = trap_precise ? trap_pc : trap_ret_pc;
          end else begin
            next_exc    = instr_pc;
            next_ras_pc = instr_pc;
          end
          next_state = fwtd_pkg::ST_BARRIER;
        end else if (instr_valid && !fetch_stall) begin
          case (opc)
            `FWTD_OP_CALL: begin
              next_is_call  = 1'b1;
              next_target   = {base[63:`FWTD_BASE_LSB], 1'b1, fn[7], fn[5:0],
                               5'h00, 1'b1};
              next_exc      = instr_pc + 64'h4;
              next_ras_pc   = instr_pc + 64'h4;
              next_ras_push = 1'b1;
              next_state    = fwtd_pkg::ST_BARRIER;
            end
            `FWTD_OP_RLD, `FWTD_OP_RST: begin
              next_raw.valid     = 1'b1;
              next_raw.store     = opc == `FWTD_OP_RST;
              next_raw.physical_address_select      = instr_word[15];
              next_raw.chk_write = opc == `FWTD_OP_RLD && instr_word[13];
              next_raw.quad      = instr_word[12];
              next_raw.pte_fetch = opc == `FWTD_OP_RLD && instr_word[11];
              next_raw.lock_cond = instr_word[10];
              next_raw.ra        = instr_word[25:21];
              next_raw.addr      = instr_rb_val
                                   + {{54{instr_word[9]}}, instr_word[9:0]};
              if (next_raw.pte_fetch) begin
                next_raw.mode = `FWTD_MODE_KERNEL;
              end else if (instr_word[14]) begin
                next_raw.mode = ctrl[`FWTD_CTRL_ALTM];
              end else begin
                next_raw.mode = ctrl[`FWTD_CTRL_DCM];
              end
              next_pz = opc == `FWTD_OP_RST || instr_word[10];
            end
            `FWTD_OP_RET: begin
              next_redirect.valid    = 1'b1;
              next_redirect.pc       = exc_ret_addr;
              next_redirect.prefetch = instr_word[15:14] == `FWTD_RET_PREFETCH;
              next_fw_mode           = exc_ret_addr[0];
              next_issue             = 1'b1;
            end
            `FWTD_OP_IRD, `FWTD_OP_IWR: begin
              next_ipr.valid   = 1'b1;
              next_ipr.write   = opc == `FWTD_OP_IWR;
              next_ipr.ra      = instr_word[25:21];
              next_ipr.index   = instr_word[15:0];
              next_ipr.latency = instr_word[`FWTD_IPR_SLOW_BIT] ? 2'h2 : 2'h1;
            end
            default: begin
            end
          endcase
        end
      end
      fwtd_pkg::ST_BARRIER: begin
        if (pipe_empty) begin
          next_state = fwtd_pkg::ST_ISSUE;
        end
      end
      fwtd_pkg::ST_ISSUE: begin
        next_issue          = is_call;
        next_redirect.valid = 1'b1;
        next_redirect.pc    = target;
        next_fw_mode        = 1'b1;
        next_cnt            = `FWTD_FLOW_MIN - 2'h1;
        next_state          = fwtd_pkg::ST_FLOW;
      end
      fwtd_pkg::ST_FLOW: begin
        next_cnt = cnt - 2'h1;
        if (cnt == 2'h0) begin
          next_state = fwtd_pkg::ST_IDLE;
        end
      end
      default: next_state = fwtd_pkg::ST_IDLE;
    endcase
    next_fetch_stall = next_state != fwtd_pkg::ST_IDLE
                       || (next_redirect.valid && !next_redirect.prefetch
                           && state == fwtd_pkg::ST_IDLE);
  end

  // Sequencer registers; reset enters firmware mode as after power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state          <= fwtd_pkg::ST_IDLE;
      cnt            <= 2'h0;
      target         <= 64'h0;
      is_call        <= 1'b0;
      last_vec       <= 4'h0;
      fetch_stall    <= 1'b0;
      firmware_mode  <= 1'b1;
      issue_pipe_one <= 1'b0;
      raw_pipe_zero  <= 1'b0;
      ras_push       <= 1'b0;
      ras_push_pc    <= 64'h0;
      redirect       <= '0;
      raw_op         <= '0;
      ipr_op         <= '0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      target         <= next_target;
      is_call        <= next_is_call;
      last_vec       <= next_last_vec;
      fetch_stall    <= next_fetch_stall;
      firmware_mode  <= next_fw_mode;
      issue_pipe_one <= next_issue;
      raw_pipe_zero  <= next_pz;
      ras_push       <= next_ras_push;
      ras_push_pc    <= next_ras_pc;
      redirect       <= next_redirect;
      raw_op         <= next_raw;
      ipr_op         <= next_ipr;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------------------------------
  // Read mux; unmapped offsets answer SLVERR with zero data
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (s_axi_araddr)
      `FWTD_OFS_BASE_LO: rd_mux = {base[31:`FWTD_BASE_LSB], 14'h0000};
      `FWTD_OFS_BASE_HI: rd_mux = base[63:32];
      `FWTD_OFS_CTRL:    rd_mux = {24'h0, ctrl};
      `FWTD_OFS_STATUS:  rd_mux = {23'h0, fetch_stall, last_vec, 3'h0, firmware_mode};
      `FWTD_OFS_EXC_LO:  rd_mux = exc_ret_addr[31:0];
      `FWTD_OFS_EXC_HI:  rd_mux = exc_ret_addr[63:32];
      default:           rd_ok  = 1'b0;
    endcase
  end

  // Address and data are latched independently; a hardware update of the
  // return address wins over a bus write in the same cycle
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_q    = aw_q;
    next_w_q     = w_q;
    next_s_q     = s_q;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_base    = base;
    next_ctrl    = ctrl;
    next_exc_all = exc_ret_addr;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_q    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_q    = s_axi_wdata;
      next_s_q    = s_axi_wstrb;
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'h0;
      case (aw_q)
        `FWTD_OFS_BASE_LO: next_base[31:0]  = merge(base[31:0], w_q, s_q);
        `FWTD_OFS_BASE_HI: next_base[63:32] = merge(base[63:32], w_q, s_q);
        `FWTD_OFS_CTRL:    next_ctrl = s_q[0] ? w_q[7:0] : ctrl;
        `FWTD_OFS_STATUS:  next_bresp = 2'h0;
        `FWTD_OFS_EXC_LO:  next_exc_all[31:0]  = merge(exc_ret_addr[31:0], w_q, s_q);
        `FWTD_OFS_EXC_HI:  next_exc_all[63:32] = merge(exc_ret_addr[63:32], w_q, s_q);
        default:           next_bresp = 2'h2;
      endcase
    end
    if (next_ras_push) begin
      next_exc_all = next_exc;
    end
    next_base[`FWTD_BASE_LSB-1:0] = 14'h0000;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_mux;
      next_rresp  = rd_ok ? 2'h0 : 2'h2;
    end
  end

  // Bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0;
      s_q           <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      base          <= `FWTD_RST_BASE;
      ctrl          <= `FWTD_RST_CTRL;
      exc_ret_addr  <= `FWTD_RST_EXC;
    end else begin
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      aw_q          <= next_aw_q;
      w_q           <= next_w_q;
      s_q           <= next_s_q;
      s_axi_awready <= !next_aw_hold;
      s_axi_wready  <= !next_w_hold;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      base          <= next_base;
      ctrl          <= next_ctrl;
      exc_ret_addr  <= next_exc_all;
    end
  end
endmodule

// *** dv/fwtd_props.sv ***
/* Port checker for the dispatch block.
   Bound to fwtd_dispatch; sees only its ports. */
`timescale 1ns/1ps
module fwtd_props (
  input wire logic                  aclk,           // Clock
  input wire logic                  aresetn,        // Reset
  input wire logic                  instr_valid,    // Slot full
  input wire logic [31:0]           instr_word,     // Instruction
  input wire logic [63:0]           instr_pc,       // Its PC
  input wire logic [63:0]           instr_rb_val,   // Base value
  input wire logic [11:0]           trap_req,       // Traps
  input wire logic                  fetch_stall,    // Held
  input wire logic                  firmware_mode,  // Mode
  input wire logic                  issue_pipe_one, // Pipe one
  input wire logic                  raw_pipe_zero,  // Pipe zero
  input wire logic                  ras_push,       // Push
  input wire logic [63:0]           ras_push_pc,    // Pushed PC
  input wire logic [63:0]           exc_ret_addr,   // Return address
  input wire fwtd_pkg::fwtd_redir_t redirect,       // Redirect
  input wire fwtd_pkg::fwtd_raw_t   raw_op,         // Raw access
  input wire fwtd_pkg::fwtd_ipr_t   ipr_op          // Register op
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Only clean instructions are judged; a pending trap may win the slot
  wire acc = instr_valid && !fetch_stall && trap_req == 12'h0;
  wire call_ok = acc && instr_word[31:6] == 26'h2;
  wire ret_ok = acc && firmware_mode && instr_word[31:26] == 6'h1e && instr_word[15]
                && instr_word[13:0] == 14'h0;
  wire st_ok = acc && firmware_mode && instr_word[31:26] == 6'h1f && !instr_word[13]
               && !instr_word[11];
  a_call_save: assert property (call_ok |=> ras_push && ras_push_pc == exc_ret_addr
    && exc_ret_addr == $past(instr_pc) + 64'h4) else $error("call return address wrong");
  a_call_stall: assert property (call_ok |=> fetch_stall [*4])
    else $error("call shorter than four cycles");
  a_call_issue: assert property (call_ok |-> ##[2:20] redirect.valid && issue_pipe_one
    && redirect.pc[13] && redirect.pc[5:0] == 6'h01) else $error("call target not issued");
  a_ret_jump: assert property (ret_ok |=> redirect.valid && issue_pipe_one
    && redirect.pc == $past(exc_ret_addr) && firmware_mode == redirect.pc[0])
    else $error("return target wrong");
  a_ret_stall: assert property (ret_ok && instr_word[14] |=> fetch_stall)
    else $error("stall return did not hold fetch");
  a_ret_prefetch: assert property (ret_ok && !instr_word[14] |=> redirect.prefetch)
    else $error("normal return did not prefetch");
  a_store_zero: assert property (st_ok |=> raw_op.valid && raw_op.store && raw_pipe_zero)
    else $error("raw store not on pipe zero");
  a_raw_addr: assert property (raw_op.valid |-> raw_op.addr == $past(instr_rb_val)
    + {{54{$past(instr_word[9])}}, $past(instr_word[9:0])}) else $error("raw address wrong");
  a_ipr_lat: assert property (ipr_op.valid |-> ipr_op.latency
    == (ipr_op.index[8] ? 2'h2 : 2'h1)) else $error("register latency wrong");
  cover property (call_ok);
  cover property (ret_ok && instr_word[14]);
  cover property (st_ok);
endmodule
bind fwtd_dispatch fwtd_props u_props (.*);

// *** dv/fwtd_pipe_model.sv ***
/* Pipeline model: says when older work has drained.
   Runs on the bench clock and watches the dispatch stall. */
`timescale 1ns/1ps
module fwtd_pipe_model (
  input  wire logic aclk,        // Clock
  input  wire logic aresetn,     // Reset
  input  wire logic fetch_stall, // Dispatch holds fetch
  input  wire logic slow,        // Older work in flight
  output logic      pipe_empty   // Nothing older can trap
);
  logic [1:0] age, next_age;
  // Slow pipe drains three cycles into the stall
  always_comb next_age = fetch_stall ? (age == 2'h3 ? age : age + 2'h1) : 2'h0;
  always_ff @(posedge aclk) age <= aresetn ? next_age : 2'h0;
  assign pipe_empty = !slow || age == 2'h3;
endmodule

// *** dv/firmware_trap_dispatch_tb.sv ***
/* Bench for the dispatch block: bus, instruction and trap tasks.
   Needs the package, checker and pipeline model. */
`timescale 1ns/1ps
module firmware_trap_dispatch_tb;
  logic aclk = '0, aresetn = '0, slow = '1, pipe_empty, instr_valid = '0, dsign_err = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, fetch_stall, firmware_mode, issue_pipe_one, raw_pipe_zero, ras_push;
  logic instr_fp = '0, instr_fp_std = '0, icache_miss = '0, trap_precise = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, instr_word = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, instr_fp_type = '0;
  logic [11:0] trap_req = '0;
  logic [63:0] instr_pc = '0, instr_rb_val = '0, trap_pc = '0, trap_ret_pc = '0;
  logic [63:0] ras_push_pc, exc_ret_addr, rd_pc;
  fwtd_pkg::fwtd_redir_t redirect;
  fwtd_pkg::fwtd_raw_t raw_op, rw;
  fwtd_pkg::fwtd_ipr_t ipr_op, ip;
  int mismatches = 0, check_count = 0, cyc = 0;
  fwtd_dispatch uut (.*);
  fwtd_pipe_model pipe (.aclk, .aresetn, .fetch_stall, .slow, .pipe_empty);
  always #5 aclk = ~aclk;
  // Keep the last redirect and accesses; a stuck run ends by cycle count
  always @(posedge aclk) begin
    if (redirect.valid) rd_pc <= redirect.pc;
    if (raw_op.valid) rw <= raw_op;
    if (ipr_op.valid) ip <= ipr_op;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= '1; s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= '1; s_axi_rready <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata; rr = s_axi_rresp;
    s_axi_rready <= '0;
  endtask
  // Held until taken; the base register follows the PC so addresses vary
  task op(input logic [31:0] w, input logic [63:0] p, input logic [11:0] t);
    instr_valid <= t == 12'h0; trap_req <= t; instr_word <= w; instr_pc <= p;
    instr_rb_val <= p; trap_pc <= p; trap_ret_pc <= p;
    @(posedge aclk);
    while (fetch_stall) @(posedge aclk);
    instr_valid <= '0; trap_req <= '0;
    repeat (2) @(posedge aclk);
    while (fetch_stall) @(posedge aclk);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    rdr(8'h10); chk("exc_reset", rd, 64'h1);
    rdr(8'h18); chk("unmapped", {rd, rr}, 64'h2);
    wr(8'h00, 32'h0001_c000); wr(8'h08, 32'h0);
    rdr(8'h00); chk("base", rd, 64'h1c000);
    op(32'h83, 64'h1000, 12'h0); chk("call", rd_pc, 64'h1f0c1);
    chk("call_exc", exc_ret_addr, 64'h1004);
    slow <= '0;
    op(32'h7c43_03fc, 64'h200, 12'h0); chk("raw", rw.addr, 64'h1fc);
    op(32'h6484_0100, 64'h240, 12'h0); chk("ipr", ip.latency, 64'h2);
    dsign_err <= '1;
    op(32'h0, 64'h500, 12'h090); chk("sign", rd_pc, 64'h1c381);
    dsign_err <= '0;
    for (int i = 8; i < 12; i++) begin
      op(32'h0, 64'h500 + i, 12'h1 << i); chk("vec", rd_pc, 64'h1c001 + i * 64'h80);
    end
    chk("trap_exc", exc_ret_addr, 64'h50b);
    $display("test entries done");
    wr(8'h10, 32'h2001); op(32'h7bff_8000, 64'h600, 12'h0); chk("ret", rd_pc, 64'h2001);
    wr(8'h10, 32'h3000); op(32'h7bff_c000, 64'h604, 12'h0);
    chk("ret_mode", firmware_mode, 64'h0);
    op(32'h7c43_03fc, 64'h700, 12'h0); chk("priv", rd_pc, 64'h1c481);
    op(32'h45, 64'h800, 12'h0); chk("bad_fn", exc_ret_addr, 64'h800);
    op(32'h05, 64'h900, 12'h0); chk("kern_fn", rd_pc, 64'h1e141);
    $display("test returns done");
    complete_run();
  end
endmodule
